// file: ass_params.svh
// Constants of the approach scan sequencer: register offsets, field positions, reset values and timing.
`ifndef ASS_PARAMS_SVH
`define ASS_PARAMS_SVH
`define ASS_OFF_CTRL      12'h000
`define ASS_OFF_APPR_IVL  12'h004
`define ASS_OFF_CAL_IVL   12'h008
`define ASS_OFF_CAL_SLOW  12'h00c
`define ASS_OFF_RX_EN     12'h010
`define ASS_OFF_THRESH    12'h014
`define ASS_OFF_STATUS    12'h018
`define ASS_OFF_MASK      12'h01c
`define ASS_OFF_STATE     12'h020
`define ASS_CTRL_WAKE_EN  0
`define ASS_CTRL_CAL_EN   1
`define ASS_CTRL_SLOW_EN  2
`define ASS_CTRL_RESET    3'h1
`define ASS_ST_APPROACH   0
`define ASS_ST_EXIT       1
`define ASS_ST_CAL_DONE   2
`define ASS_RX_EN_RESET   5'h01
`define ASS_CAL_RX_MASK   5'h1f
`define ASS_SLOW_HZ       32000
`define ASS_APPR_MS       20
`define ASS_CAL_FAST_MS   2000
`define ASS_CAL_SLOW_MS   10000
`define ASS_SLOW_AFTER_MS 60000
`define ASS_SCAN_TICKS    8'h04
`define ASS_THRESH_RESET  16'h0100
`endif

// file: ass_pkg.sv
// Types shared by the approach scan sequencer.
package ass_pkg;
  typedef enum logic [1:0] {ASS_SLEEP, ASS_APPR_SCAN, ASS_CAL_SCAN, ASS_AWAKE} ass_state_type;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ass_apb_req_type;
endpackage : ass_pkg

// file: ass_sequencer.sv
// Approach scan sequencer with APB registers, slow tick sync and wake interrupt.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`include "ass_params.svh"
// How it works
// (R1) Each scan phase runs an approach scan; one receive channel enabled after reset.
// (R2) Approach scans are spaced by a software set interval of slow ticks.
// (R3) Any enabled channel change above threshold wakes device and host.
// (R4) Enabled calibration scans run in a scan phase on all five channels.
// (R5) Calibration scans repeat at their own configurable interval.
// (R6) Optionally the calibration interval lengthens after a minute without approach.
// (R7) Calibration scans can be disabled, leaving approach scans alone.
// (R8) A detected approach raises the host interrupt.
// (R9) Sleep and scan alternation is timed by slow oscillator ticks.
// (R10) Tick defaults assume a slow oscillator of about 32 kHz.
// (R11) External interrupt, serial start, clear or watchdog leave wake mode; clear and watchdog only return to sleep, ctrl is kept and scans resume.
// (R12) An approach beyond threshold moves the device to processing mode.
// (R13) Intervals are tick counters reloaded per interval and reset by master clear.
module ass_sequencer
  import ass_pkg::*;
#(
  parameter int RX_N = 5                                // Receive channel count.
) (
  input  wire logic                  i_mclk,            // System clock, 40 MHz.
  input  wire logic                  i_rst_n,           // Synchronous reset, active low.
  input  wire logic                  i_ce,              // Clock enable; low freezes state.
  input  wire logic                  i_master_clear_pin_n, // Master clear pin, active low.
  input  wire logic                  i_watchdog_reset_source, // Watchdog reset request.
  input  wire logic                  i_external_wake_interrupt, // External wake pin.
  input  wire logic                  i_serial_start,    // Start condition seen on first serial port.
  input  wire logic                  i_slow_scan_oscillator, // Slow oscillator pin, about 32 kHz.
  input  wire logic [RX_N-1:0][15:0] i_rx_delta,        // Per channel signal change magnitude.
  input  wire logic                  i_psel,            // APB select.
  input  wire logic                  i_penable,         // APB enable.
  input  wire logic                  i_pwrite,          // APB write.
  input  wire logic [11:0]           i_paddr,           // APB byte address.
  input  wire logic [31:0]           i_pwdata,          // APB write data.
  output logic [31:0]                o_prdata,          // APB read data.
  output logic                       o_pready,          // APB ready, always high.
  output logic                       o_pslverr,         // APB error on unmapped address.
  output logic [RX_N-1:0]            o_rx_active,       // Channels powered for the current scan.
  output logic                       o_approach_scan,   // Approach scan in progress.
  output logic                       o_cal_scan,        // Calibration scan in progress.
  output logic                       o_processing_mode, // Device left self wake-up mode.
  output logic                       o_irq              // Level interrupt to host.
);
  localparam logic [23:0] APPR_TICKS = 24'((`ASS_APPR_MS * `ASS_SLOW_HZ) / 1000);
  localparam logic [23:0] CAL_FAST   = 24'((`ASS_CAL_FAST_MS * `ASS_SLOW_HZ) / 1000);
  localparam logic [23:0] CAL_SLOW   = 24'((`ASS_CAL_SLOW_MS * `ASS_SLOW_HZ) / 1000);
  localparam logic [23:0] SLOW_AFTER = 24'((`ASS_SLOW_AFTER_MS * `ASS_SLOW_HZ) / 1000); // R10

  ass_apb_req_type req;
  ass_state_type   state, next_state;
  logic [2:0]  sync_lso, sync_mc, sync_wd, sync_ext;
  logic        tick, clr;
  logic [2:0]  ctrl, next_ctrl;
  logic [23:0] appr_ivl, next_appr_ivl, cal_ivl, next_cal_ivl, cal_slow_ivl, next_cal_slow_ivl;
  logic [RX_N-1:0] rx_en, next_rx_en;
  logic [15:0] thresh, next_thresh;
  logic [2:0]  status, next_status, mask, next_mask;
  logic [23:0] appr_cnt, next_appr_cnt, cal_cnt, next_cal_cnt, idle_cnt, next_idle_cnt;
  logic [7:0]  scan_cnt, next_scan_cnt;
  logic        cal_due, next_cal_due;
  logic [RX_N-1:0] hit;
  logic        approach, exit_evt, wr, rd, stat_rd;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite, paddr: i_paddr, pwdata: i_pwdata};
  assign wr  = req.psel && req.penable && req.pwrite;
  assign rd  = req.psel && !req.penable && !req.pwrite;
  assign stat_rd = req.psel && req.penable && !req.pwrite && (req.paddr == `ASS_OFF_STATUS);

  // Pins pass two flops; the third stage only serves edge detection of the slow clock.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sync_lso <= 3'h0;
      sync_mc  <= 3'h7;
      sync_wd  <= 3'h0;
      sync_ext <= 3'h0;
    end else if (i_ce) begin
      sync_lso <= {sync_lso[1:0], i_slow_scan_oscillator};
      sync_mc  <= {sync_mc[1:0], i_master_clear_pin_n};
      sync_wd  <= {sync_wd[1:0], i_watchdog_reset_source};
      sync_ext <= {sync_ext[1:0], i_external_wake_interrupt};
    end
  end

  // One tick per slow oscillator rising edge; read only from the second and third stage.
  assign tick = sync_lso[1] && !sync_lso[2]; // R9
  assign clr  = !sync_mc[1] || sync_wd[1];   // R11

  // Threshold compare per receive channel.
  for (genvar g = 0; g < RX_N; g++) begin : g_cmp
    assign hit[g] = rx_en[g] && (i_rx_delta[g] > thresh); // R3
  end
  assign approach = (state == ASS_APPR_SCAN) && (|hit);
  assign exit_evt = (state != ASS_AWAKE) && ctrl[`ASS_CTRL_WAKE_EN] &&
                    (approach || sync_ext[1] || i_serial_start); // R11

  // Register file next values; status set wins over read clear.
  always_comb begin
    next_ctrl         = ctrl;
    next_appr_ivl     = appr_ivl;
    next_cal_ivl      = cal_ivl;
    next_cal_slow_ivl = cal_slow_ivl;
    next_rx_en        = rx_en;
    next_thresh       = thresh;
    next_mask         = mask;
    next_status       = status;
    next_prdata       = o_prdata;
    next_pslverr      = 1'b0;
    if (wr) begin
      case (req.paddr)
        `ASS_OFF_CTRL:     next_ctrl = req.pwdata[2:0];
        `ASS_OFF_APPR_IVL: next_appr_ivl = req.pwdata[23:0];     // R2
        `ASS_OFF_CAL_IVL:  next_cal_ivl = req.pwdata[23:0];      // R5
        `ASS_OFF_CAL_SLOW: next_cal_slow_ivl = req.pwdata[23:0]; // R6
        `ASS_OFF_RX_EN:    next_rx_en = req.pwdata[RX_N-1:0];    // R1
        `ASS_OFF_THRESH:   next_thresh = req.pwdata[15:0];
        `ASS_OFF_MASK:     next_mask = req.pwdata[2:0];
        `ASS_OFF_STATUS, `ASS_OFF_STATE: next_pslverr = 1'b0;
        default:           next_pslverr = 1'b1;
      endcase
    end
    if (rd) begin
      case (req.paddr)
        `ASS_OFF_CTRL:     next_prdata = {29'h0, ctrl};
        `ASS_OFF_APPR_IVL: next_prdata = {8'h0, appr_ivl};
        `ASS_OFF_CAL_IVL:  next_prdata = {8'h0, cal_ivl};
        `ASS_OFF_CAL_SLOW: next_prdata = {8'h0, cal_slow_ivl};
        `ASS_OFF_RX_EN:    next_prdata = {{(32-RX_N){1'b0}}, rx_en};
        `ASS_OFF_THRESH:   next_prdata = {16'h0, thresh};
        `ASS_OFF_STATUS:   next_prdata = {29'h0, status};
        `ASS_OFF_MASK:     next_prdata = {29'h0, mask};
        `ASS_OFF_STATE:    next_prdata = {30'h0, state};
        default:           next_prdata = 32'h0;
      endcase
    end
    if (stat_rd) begin
      next_status = 3'h0;
    end
    if (!(req.psel && req.penable && !req.pwrite) && rd) begin
      next_pslverr = 1'b0;
    end
    // Unmapped addresses flag from the setup edge, so the error stands in the access phase for both directions.
    if (req.psel && !(req.paddr inside {`ASS_OFF_CTRL, `ASS_OFF_APPR_IVL, `ASS_OFF_CAL_IVL,
        `ASS_OFF_CAL_SLOW, `ASS_OFF_RX_EN, `ASS_OFF_THRESH, `ASS_OFF_STATUS, `ASS_OFF_MASK, `ASS_OFF_STATE})) begin
      next_pslverr = 1'b1;
    end
    if (approach) begin
      next_status[`ASS_ST_APPROACH] = 1'b1; // R8
    end
    if (exit_evt) begin
      next_status[`ASS_ST_EXIT] = 1'b1;
    end
    if (state == ASS_CAL_SCAN && tick && scan_cnt == 8'h00) begin
      next_status[`ASS_ST_CAL_DONE] = 1'b1;
    end
  end

  // Register file flops.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl         <= `ASS_CTRL_RESET;
      appr_ivl     <= APPR_TICKS;
      cal_ivl      <= CAL_FAST;
      cal_slow_ivl <= CAL_SLOW;
      rx_en        <= RX_N'(`ASS_RX_EN_RESET);
      thresh       <= `ASS_THRESH_RESET;
      status       <= 3'h0;
      mask         <= 3'h0;
      o_prdata     <= 32'h0;
      o_pslverr    <= 1'b0;
    end else if (i_ce) begin
      ctrl         <= next_ctrl;
      appr_ivl     <= next_appr_ivl;
      cal_ivl      <= next_cal_ivl;
      cal_slow_ivl <= next_cal_slow_ivl;
      rx_en        <= next_rx_en;
      thresh       <= next_thresh;
      status       <= next_status;
      mask         <= next_mask;
      o_prdata     <= next_prdata;
      o_pslverr    <= next_pslverr;
    end
  end

  // Scan scheduler; clear and watchdog return everything to sleep with fresh interval and idle counters.
  always_comb begin
    next_state    = state;
    next_appr_cnt = appr_cnt;
    next_cal_cnt  = cal_cnt;
    next_idle_cnt = idle_cnt;
    next_scan_cnt = scan_cnt;
    next_cal_due  = cal_due;
    case (state)
      ASS_SLEEP: begin
        if (tick) begin
          if (idle_cnt != SLOW_AFTER) next_idle_cnt = idle_cnt + 24'h1;
          if (cal_cnt == 24'h0) begin
            next_cal_due = ctrl[`ASS_CTRL_CAL_EN]; // R7
            next_cal_cnt = (ctrl[`ASS_CTRL_SLOW_EN] && idle_cnt == SLOW_AFTER) ? cal_slow_ivl : cal_ivl; // R6
          end else begin
            next_cal_cnt = cal_cnt - 24'h1; // R5
          end
          if (appr_cnt == 24'h0) begin
            next_appr_cnt = appr_ivl; // R13
            next_scan_cnt = `ASS_SCAN_TICKS;
            next_state    = ASS_APPR_SCAN; // R1
          end else begin
            next_appr_cnt = appr_cnt - 24'h1; // R2
          end
        end
      end
      ASS_APPR_SCAN: begin
        if (tick) begin
          if (scan_cnt != 8'h00) begin
            next_scan_cnt = scan_cnt - 8'h01;
          end else if (cal_due) begin
            next_cal_due  = 1'b0;
            next_scan_cnt = `ASS_SCAN_TICKS;
            next_state    = ASS_CAL_SCAN; // R4
          end else begin
            next_state = ASS_SLEEP;
          end
        end
      end
      ASS_CAL_SCAN: begin
        if (tick && scan_cnt != 8'h00) next_scan_cnt = scan_cnt - 8'h01;
        else if (tick) next_state = ASS_SLEEP;
      end
      ASS_AWAKE: begin
        if (!ctrl[`ASS_CTRL_WAKE_EN]) begin
          next_state    = ASS_SLEEP;
          next_idle_cnt = 24'h0;
          next_appr_cnt = appr_ivl;
        end
      end
      default: next_state = ASS_SLEEP;
    endcase
    if (exit_evt) begin
      next_state    = ASS_AWAKE; // R12
      next_idle_cnt = 24'h0;
    end
    if (!ctrl[`ASS_CTRL_WAKE_EN] && state != ASS_AWAKE) begin
      next_state = ASS_SLEEP;
    end
    if (clr) begin
      next_state    = ASS_SLEEP;
      next_appr_cnt = appr_ivl; // R13
      next_cal_cnt  = cal_ivl;
      next_idle_cnt = 24'h0;
      next_cal_due  = 1'b0;
    end
  end

  // Scheduler flops.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state    <= ASS_SLEEP;
      appr_cnt <= APPR_TICKS;
      cal_cnt  <= CAL_FAST;
      idle_cnt <= 24'h0;
      scan_cnt <= 8'h00;
      cal_due  <= 1'b0;
    end else if (i_ce) begin
      state    <= next_state;
      appr_cnt <= next_appr_cnt;
      cal_cnt  <= next_cal_cnt;
      idle_cnt <= next_idle_cnt;
      scan_cnt <= next_scan_cnt;
      cal_due  <= next_cal_due;
    end
  end

  // Outputs follow state; the wake interrupt stays until status is read or its mask bit is cleared.
  assign o_pready          = 1'b1;
  assign o_approach_scan   = (state == ASS_APPR_SCAN);
  assign o_cal_scan        = (state == ASS_CAL_SCAN);
  assign o_processing_mode = (state == ASS_AWAKE);
  assign o_rx_active       = (state == ASS_APPR_SCAN) ? rx_en :
                             (state == ASS_CAL_SCAN) ? RX_N'(`ASS_CAL_RX_MASK) : '0; // R4
  assign o_irq             = |(status & mask); // R8

  property p_appr_irq;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && approach && !clr && ctrl[`ASS_CTRL_WAKE_EN]) |=> status[`ASS_ST_APPROACH];
  endproperty
  a_appr_irq: assert property (p_appr_irq) else $error("approach did not set status"); // R8
  property p_wake;
    @(posedge i_mclk) disable iff (!i_rst_n) (i_ce && exit_evt && !clr) |=> o_processing_mode;
  endproperty
  a_wake: assert property (p_wake) else $error("exit event did not wake"); // R12
  property p_clear;
    @(posedge i_mclk) disable iff (!i_rst_n) (i_ce && clr) |=> (state == ASS_SLEEP && appr_cnt == appr_ivl);
  endproperty
  a_clear: assert property (p_clear) else $error("master clear did not reset"); // R13
  property p_cal_rx;
    @(posedge i_mclk) disable iff (!i_rst_n) o_cal_scan |-> (o_rx_active == RX_N'(`ASS_CAL_RX_MASK));
  endproperty
  a_cal_rx: assert property (p_cal_rx) else $error("calibration channels wrong"); // R4
  property p_no_cal;
    @(posedge i_mclk) disable iff (!i_rst_n) (!ctrl[`ASS_CTRL_CAL_EN] && !cal_due && !o_cal_scan) |=> !o_cal_scan;
  endproperty
  a_no_cal: assert property (p_no_cal) else $error("calibration ran while disabled"); // R7
  property p_irq;
    @(posedge i_mclk) disable iff (!i_rst_n) (i_ce && |(status & mask) && !stat_rd && !wr) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq dropped before status read"); // R8
  property p_appr_start;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && state == ASS_SLEEP && tick && appr_cnt == 24'h0 && !exit_evt && !clr && ctrl[`ASS_CTRL_WAKE_EN])
      |=> o_approach_scan;
  endproperty
  a_appr_start: assert property (p_appr_start) else $error("approach scan did not start"); // R2
  property p_scan_rx;
    @(posedge i_mclk) disable iff (!i_rst_n) o_approach_scan |-> (o_rx_active == rx_en);
  endproperty
  a_scan_rx: assert property (p_scan_rx) else $error("approach channels wrong"); // R1
  c_appr: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_approach_scan);
  c_cal: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_cal_scan);
  c_wake: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_processing_mode && o_irq);
endmodule : ass_sequencer

// file: ass_host_model.sv
// Host model that counts the wake interrupts raised by the sequencer.
`timescale 1ns/1ps
module ass_host_model (
  input  wire logic       i_mclk,  // System clock.
  input  wire logic       i_rst_n, // Synchronous reset, active low.
  input  wire logic       i_irq,   // Level interrupt from the sequencer.
  output logic [7:0]      o_wakes  // Rising edges of the interrupt seen.
);
  logic prev;
  // A level held high is one wake event, so only rising edges are counted.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      prev <= 1'b0;
      o_wakes <= 8'h00;
    end else begin
      prev <= i_irq;
      if (i_irq && !prev) o_wakes <= o_wakes + 8'h01;
    end
  end
endmodule : ass_host_model

// file: approach_scan_sequencer_tb_top.sv
// Self-checking testbench of the approach scan sequencer.
`timescale 1ns/1ps
`include "ass_params.svh"
module approach_scan_sequencer_tb_top;
  logic             clk = 0, rst_n = 0, mc_n = 1, wdog = 0, ext = 0, ser = 0, osc = 0, ce = 1;
  logic             psel = 0, pen = 0, pwr = 0, e, pready, pslverr, appr, cal, proc, irq;
  logic [11:0]      padr = 12'h000;
  logic [31:0]      pwd = 32'h0, rd, prdata;
  logic [4:0][15:0] dlt = '0;
  logic [4:0]       rxa;
  logic [7:0]       wakes;
  logic [3:0]       tc = 4'h0;
  int               failures = 0, checks = 0, cyc = 0, n;
  localparam logic [11:0] RA [8] = '{`ASS_OFF_CTRL, `ASS_OFF_APPR_IVL, `ASS_OFF_CAL_IVL,
    `ASS_OFF_CAL_SLOW, `ASS_OFF_RX_EN, `ASS_OFF_THRESH, `ASS_OFF_STATUS, `ASS_OFF_STATE};
  localparam logic [31:0] RE [8] = '{32'h1, 32'h280, 32'hfa00, 32'h4e200, 32'h1, 32'h100, 32'h0, 32'h0};
  // The clock runs at 40 MHz.
  initial forever #12.5 clk = ~clk;
  // Slow oscillator at one sixteenth of the clock keeps the scan schedule short.
  always @(posedge clk) begin
    tc <= tc + 4'h1;
    osc <= tc[3];
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      close_out();
    end
  end
  ass_sequencer uut (.i_mclk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_master_clear_pin_n(mc_n),
    .i_watchdog_reset_source(wdog), .i_external_wake_interrupt(ext), .i_serial_start(ser),
    .i_slow_scan_oscillator(osc), .i_rx_delta(dlt), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_rx_active(rxa), .o_approach_scan(appr), .o_cal_scan(cal), .o_processing_mode(proc), .o_irq(irq));
  ass_host_model host (.i_mclk(clk), .i_rst_n(rst_n), .i_irq(irq), .o_wakes(wakes));
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  function automatic logic pick(input int k);
    case (k)
      0: return appr;
      1: return cal;
      default: return proc;
    endcase
  endfunction : pick
  // Bounded wait for a status output; a hang here counts as a mismatch.
  task automatic wt(input int k, input logic v);
    int c;
    c = 0;
    while (pick(k) !== v && c < 3000) begin
      @(posedge clk);
      #1;
      c++;
    end
    if (c >= 3000) chk("wait", 32'h1, 32'h0);
  endtask : wt
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // Main sequence: table of reset values first, then the hand-written cases.
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk("reset value", RE[i], rd);
    end
    $display("test reset values done");
    apb(1'b1, 12'h024, 32'h5a5a5a5a);
    chk("slverr", 32'h1, e);
    apb(1'b0, 12'h024, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("slverr read", 32'h1, e);
    $display("test unmapped done");
    apb(1'b1, `ASS_OFF_APPR_IVL, 32'h2);
    apb(1'b1, `ASS_OFF_CAL_IVL, 32'h2);
    apb(1'b1, `ASS_OFF_CAL_SLOW, 32'h3);
    apb(1'b0, `ASS_OFF_CAL_SLOW, 32'h0);
    chk("slow interval", 32'h3, rd);
    // Writing an interval does not reload a running counter, so a master clear starts the short schedule.
    mc_n <= 1'b0;
    repeat (4) @(posedge clk);
    mc_n <= 1'b1;
    wt(0, 1'b1);
    chk("rx single", 32'h1, rxa);
    apb(1'b1, `ASS_OFF_RX_EN, 32'h3);
    wt(0, 1'b0);
    wt(0, 1'b1);
    chk("rx pair", 32'h3, rxa);
    $display("test approach scans done");
    apb(1'b1, `ASS_OFF_CTRL, 32'h3);
    wt(1, 1'b1);
    chk("cal rx", `ASS_CAL_RX_MASK, rxa);
    wt(1, 1'b0);
    apb(1'b1, `ASS_OFF_CTRL, 32'h1);
    apb(1'b0, `ASS_OFF_STATUS, 32'h0);
    chk("cal done", 32'h1, rd[2]);
    apb(1'b0, `ASS_OFF_STATUS, 32'h0);
    chk("cal cleared", 32'h0, rd[2]);
    n = 0;
    repeat (800) begin
      @(posedge clk);
      n += cal;
    end
    chk("cal off", 32'h0, n);
    $display("test calibration done");
    apb(1'b1, `ASS_OFF_MASK, 32'h1);
    @(posedge clk);
    dlt[0] <= 16'h0100;
    dlt[4] <= 16'hffff;
    wt(0, 1'b1);
    wt(0, 1'b0);
    chk("no wake", 32'h0, proc);
    @(posedge clk);
    dlt[0] <= 16'h0101;
    wt(2, 1'b1);
    chk("irq", 32'h1, irq);
    // The host counts the rising edge one clock after the interrupt appears.
    @(posedge clk);
    #1;
    chk("host wakes", 32'h1, wakes);
    @(posedge clk);
    dlt <= '0;
    apb(1'b0, `ASS_OFF_STATUS, 32'h0);
    chk("approach flag", 32'h1, rd[0]);
    @(posedge clk);
    #1;
    chk("irq cleared", 32'h0, irq);
    apb(1'b1, `ASS_OFF_CTRL, 32'h0);
    apb(1'b0, `ASS_OFF_STATE, 32'h0);
    chk("back to sleep", 32'h0, rd);
    $display("test approach wake done");
    apb(1'b1, `ASS_OFF_CTRL, 32'h1);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      if (k == 0) ext <= 1'b1;
      else ser <= 1'b1;
      wt(2, 1'b1);
      chk("wake source", 32'h1, proc);
      @(posedge clk);
      ext <= 1'b0;
      ser <= 1'b0;
      if (k == 0) mc_n <= 1'b0;
      else wdog <= 1'b1;
      repeat (4) @(posedge clk);
      mc_n <= 1'b1;
      wdog <= 1'b0;
      wt(2, 1'b0);
      apb(1'b0, `ASS_OFF_STATE, 32'h0);
      chk("cleared state", 32'h0, rd);
    end
    $display("test wake sources done");
    // With the clock enable low no scan may start, although several ticks pass.
    ce <= 1'b0;
    n = 0;
    repeat (300) begin
      @(posedge clk);
      n += appr;
    end
    chk("frozen", 32'h0, n);
    ce <= 1'b1;
    wt(0, 1'b1);
    $display("test clock enable done");
    close_out();
  end
endmodule : approach_scan_sequencer_tb_top
